// ==== core/ssl_core.sv ====
`timescale 1ns/100ps
module ssl_core #(
	parameter bit IS_DESER = 1'b0,
	parameter int unsigned SLEEP_TIMEOUT_CYCLES = ssl_pkg::SLEEP_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ssl_pkg::APB_AW-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// straps and powerdown pin
	input wire logic powerdown_n_in,
	input wire logic control_side_select_in,
	input wire logic autostart_strap_n_in,
	input wire logic remote_sleep_start_strap_in,
	// link status from the phy
	input wire logic pixel_clock_locked_in,
	input wire logic osc_locked_in,
	input wire logic link_activity_in,
	input wire logic video_lock_in,
	input wire logic config_lock_in,
	input wire logic wake_signal_in,
	input wire logic wake_frame_in,
	// link control
	output logic tx_enable_out,
	output logic osc_clock_select_out,
	output logic parallel_out_enable_out,
	output logic lock_out,
	output logic wake_signal_out,
	output logic ctrl_channel_ready_out,
	output logic low_power_out
);
	import ssl_pkg::*;

	ssl_state_e state_reg;
	ssl_state_e state_next;
	logic sleep_bit_reg;
	logic sleep_bit_next;
	logic sle_reg;
	logic sle_next;
	logic cle_reg;
	logic cle_next;
	logic [2:0] strap_reg;
	logic wframe_d_reg;
	logic tx_d_reg;
	logic wake_out_reg;
	logic [31:0] prdata_reg;

	wire logic [SYNC_W-1:0] raw_pins;
	wire logic [SYNC_W-1:0] pins_s;
	wire logic pd_n_s;
	wire logic side_sel_s;
	wire logic autostart_n_s;
	wire logic remote_sleep_s;
	wire logic pclk_ok_s;
	wire logic osc_ok_s;
	wire logic act_s;
	wire logic vlock_s;
	wire logic clock_s;
	wire logic wsig_s;
	wire logic wframe_s;

	generate
		if (SLEEP_TIMEOUT_CYCLES < 2) begin : g_chk
			$error("ssl_core: SLEEP_TIMEOUT_CYCLES must be at least 2");
		end
	endgenerate

	assign raw_pins = {
		wake_frame_in,
		wake_signal_in,
		config_lock_in,
		video_lock_in,
		link_activity_in,
		osc_locked_in,
		pixel_clock_locked_in,
		remote_sleep_start_strap_in,
		autostart_strap_n_in,
		control_side_select_in,
		powerdown_n_in
	};

	ssl_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.async_in(raw_pins),
		.sync_out(pins_s)
	);

	assign pd_n_s = pins_s[IN_PD];
	assign side_sel_s = pins_s[IN_SIDE_SEL];
	assign autostart_n_s = pins_s[IN_AUTOSTART];
	assign remote_sleep_s = pins_s[IN_REMOTE_SLEEP];
	assign pclk_ok_s = pins_s[IN_PCLK_OK];
	assign osc_ok_s = pins_s[IN_OSC_OK];
	assign act_s = pins_s[IN_ACT];
	assign vlock_s = pins_s[IN_VLOCK];
	assign clock_s = pins_s[IN_CLOCK];
	assign wsig_s = pins_s[IN_WSIG];
	assign wframe_s = pins_s[IN_WFRAME];

	// startup case from the straps as they stand at release
	wire logic release_now;
	wire ssl_state_e startup_state;
	wire logic startup_sleep;
	assign release_now = (state_reg == ST_OFF) && pd_n_s;
	assign startup_state = IS_DESER ?
		((!side_sel_s && remote_sleep_s) ? ST_SLEEP : ST_STANDBY) :
		(!autostart_n_s ? ST_VIDEO : (side_sel_s ? ST_SLEEP : ST_STANDBY));
	assign startup_sleep = (startup_state == ST_SLEEP);

	// held strap copy selects the controller side
	wire logic mcu_side;
	wire logic go_sleep;
	wire logic lock_any;
	wire logic wframe_rise;
	wire ssl_state_e resume_state;
	assign mcu_side = IS_DESER ? strap_reg[0] : !strap_reg[0];
	assign go_sleep = sleep_bit_reg && !mcu_side;
	assign lock_any = vlock_s || clock_s;
	assign wframe_rise = wframe_s && !wframe_d_reg;
	assign resume_state = sle_reg ? ST_VIDEO : (cle_reg ? ST_CFG : ST_STANDBY);

	// sleep timeout shared by pending sleep and wake wait
	wire logic tmr_start;
	wire logic tmr_run;
	wire logic tmr_expired;
	assign tmr_start = (state_next != state_reg) &&
		((state_next == ST_SLEEP_PEND) || (state_next == ST_WAKE_WAIT));
	assign tmr_run = (state_reg == ST_SLEEP_PEND) || (state_reg == ST_WAKE_WAIT);

	ssl_timer #(
		.CYCLES(SLEEP_TIMEOUT_CYCLES)
	) u_timer (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.start_in(tmr_start),
		.run_in(tmr_run),
		.expired_out(tmr_expired)
	);

	// apb decode
	wire logic hit_ctrl;
	wire logic hit_status;
	wire logic acc_phase;
	wire logic wr_ctrl;
	wire logic rd_setup;
	wire logic [31:0] ctrl_word;
	wire logic [31:0] status_word;
	wire logic [31:0] rd_value;
	assign hit_ctrl = (paddr_in == CTRL_OFS);
	assign hit_status = (paddr_in == STATUS_OFS);
	assign acc_phase = psel_in && penable_in;
	assign wr_ctrl = acc_phase && pwrite_in && hit_ctrl;
	assign rd_setup = psel_in && !penable_in && !pwrite_in;
	assign ctrl_word = {29'h0000_0000, cle_reg, sle_reg, sleep_bit_reg};
	assign status_word = {18'h0_0000, strap_reg, mcu_side, ctrl_channel_ready_out,
		lock_out, 1'b0, state_reg};
	assign rd_value = hit_ctrl ? ctrl_word : (hit_status ? status_word : 32'h0000_0000);
	assign pready_out = 1'b1;
	assign pslverr_out = acc_phase && !hit_ctrl && !hit_status;
	assign prdata_out = prdata_reg;

	always_comb begin
		state_next = state_reg;
		if (!pd_n_s) begin
			state_next = ST_OFF;
		end else begin
			case (state_reg)
				ST_OFF: begin
					state_next = startup_state;
				end
				ST_STANDBY: begin
					if (go_sleep) begin
						state_next = IS_DESER ? ST_SLEEP_PEND : ST_SLEEP;
					end else if (!IS_DESER && sle_reg) begin
						state_next = ST_VIDEO;
					end else if (!IS_DESER && cle_reg) begin
						state_next = ST_CFG;
					end
				end
				ST_CFG: begin
					if (go_sleep) begin
						state_next = ST_SLEEP;
					end else if (sle_reg) begin
						state_next = ST_VIDEO;
					end else if (!cle_reg) begin
						state_next = ST_STANDBY;
					end
				end
				ST_VIDEO: begin
					if (go_sleep) begin
						state_next = ST_SLEEP;
					end else if (!sle_reg) begin
						state_next = cle_reg ? ST_CFG : ST_STANDBY;
					end
				end
				ST_SLEEP_PEND: begin
					if (!sleep_bit_reg) begin
						state_next = ST_STANDBY;
					end else if (!act_s || tmr_expired) begin
						state_next = ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (!sleep_bit_reg) begin
						state_next = IS_DESER ? ST_STANDBY : resume_state;
					end else if (IS_DESER ? wsig_s : wframe_rise) begin
						state_next = ST_WAKE_WAIT;
					end
				end
				ST_WAKE_WAIT: begin
					if (IS_DESER && lock_any) begin
						state_next = ST_STANDBY;
					end else if (!IS_DESER && !sleep_bit_reg) begin
						state_next = resume_state;
					end else if (tmr_expired) begin
						state_next = ST_SLEEP;
					end
				end
				default: begin
					state_next = ST_OFF;
				end
			endcase
		end
	end

	always_comb begin
		sleep_bit_next = sleep_bit_reg;
		if (release_now) begin
			sleep_bit_next = startup_sleep;
		end else if (mcu_side) begin
			sleep_bit_next = 1'b0;
		end else if (wr_ctrl) begin
			sleep_bit_next = pwdata_in[CTRL_SLEEP_BIT];
		end else if (IS_DESER && (state_reg == ST_WAKE_WAIT) && lock_any) begin
			sleep_bit_next = 1'b0;
		end
	end

	always_comb begin
		sle_next = sle_reg;
		cle_next = cle_reg;
		if (release_now) begin
			sle_next = !IS_DESER && !autostart_n_s;
			cle_next = CTRL_CLE_RST;
		end else if (wr_ctrl) begin
			sle_next = pwdata_in[CTRL_SLE_BIT];
			cle_next = pwdata_in[CTRL_CLE_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= ST_OFF;
			sleep_bit_reg <= CTRL_SLEEP_RST;
			sle_reg <= CTRL_SLE_RST;
			cle_reg <= CTRL_CLE_RST;
		end else begin
			state_reg <= state_next;
			sleep_bit_reg <= sleep_bit_next;
			sle_reg <= sle_next;
			cle_reg <= cle_next;
		end
	end

	// straps held from release to the next powerdown release
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strap_reg <= 3'h0;
		end else if (release_now) begin
			strap_reg <= {remote_sleep_s, autostart_n_s, side_sel_s};
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wframe_d_reg <= 1'b0;
			tx_d_reg <= 1'b0;
			wake_out_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			wframe_d_reg <= wframe_s;
			tx_d_reg <= tx_enable_out;
			wake_out_reg <= tx_enable_out && !tx_d_reg;
			if (rd_setup) begin
				prdata_reg <= rd_value;
			end
		end
	end

	// link control outputs
	wire logic clk_ok;
	wire logic awake;
	wire logic video_up;
	assign osc_clock_select_out = !IS_DESER && (state_reg == ST_CFG);
	assign clk_ok = osc_clock_select_out ? osc_ok_s : pclk_ok_s;
	assign tx_enable_out = !IS_DESER && clk_ok &&
		((state_reg == ST_VIDEO) || (state_reg == ST_CFG));
	assign awake = (state_reg == ST_STANDBY) || (state_reg == ST_CFG) ||
		(state_reg == ST_VIDEO) || (state_reg == ST_SLEEP_PEND);
	assign video_up = vlock_s &&
		(IS_DESER ? ((state_reg == ST_STANDBY) || (state_reg == ST_SLEEP_PEND)) :
		(state_reg == ST_VIDEO));
	assign lock_out = video_up;
	assign parallel_out_enable_out = IS_DESER && video_up;
	assign ctrl_channel_ready_out = awake && lock_any;
	assign wake_signal_out = wake_out_reg;
	assign low_power_out = (state_reg == ST_SLEEP) || (state_reg == ST_OFF);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);

	chk_lock_video_only: assert property (
		lock_out |-> vlock_s && !osc_clock_select_out && (state_reg != ST_CFG))
		else $error("lock shown without video link");
	chk_mcu_never_sleeps: assert property (
		mcu_side && $past(mcu_side) && !$past(release_now)
		|-> !sleep_bit_reg && (state_reg != ST_SLEEP))
		else $error("controller side device holds sleep");
	chk_ser_sleep_now: assert property (
		!IS_DESER && pd_n_s && go_sleep &&
		(state_reg inside {ST_STANDBY, ST_CFG, ST_VIDEO})
		|=> state_reg == ST_SLEEP)
		else $error("serializer did not sleep at once");
	chk_deser_sleep_idle: assert property (
		IS_DESER && pd_n_s && (state_reg == ST_SLEEP_PEND) && sleep_bit_reg && !act_s
		|=> state_reg == ST_SLEEP)
		else $error("deserializer missed sleep on inactivity");
	chk_cfg_osc_clock: assert property (
		(state_reg == ST_CFG) |-> osc_clock_select_out && !parallel_out_enable_out &&
		(tx_enable_out == osc_ok_s))
		else $error("config link clocking wrong");
	chk_video_over_cfg: assert property (
		pd_n_s && (state_reg == ST_CFG) && sle_reg && !go_sleep
		|=> state_reg == ST_VIDEO ##1 osc_clock_select_out == 1'b0)
		else $error("video link did not override config");
	chk_wake_timeout: assert property (
		pd_n_s && tmr_expired && (state_reg == ST_WAKE_WAIT) && sleep_bit_reg &&
		!(IS_DESER && lock_any) |=> (state_reg == ST_SLEEP) && sleep_bit_reg)
		else $error("wake wait did not return to sleep");
	chk_deser_wake_clear: assert property (
		IS_DESER && pd_n_s && (state_reg == ST_WAKE_WAIT) && lock_any && !mcu_side
		|=> !sleep_bit_reg && (state_reg == ST_STANDBY))
		else $error("woken deserializer kept sleep bit");
	chk_straps_held: assert property (
		(state_reg != ST_OFF) && ($past(state_reg) != ST_OFF) |-> $stable(strap_reg))
		else $error("straps changed outside release");
	chk_wake_pulse: assert property (
		$rose(tx_enable_out) |=> wake_signal_out ##1 !wake_signal_out)
		else $error("wake pulse not sent after lock");
	chk_ccrdy_link: assert property (
		ctrl_channel_ready_out |-> !low_power_out && (vlock_s || clock_s))
		else $error("control channel ready without link");

	cov_autostart: cover property ((state_reg == ST_OFF) ##1 (state_reg == ST_VIDEO));
	cov_wake_ok: cover property ((state_reg == ST_WAKE_WAIT) ##1 (state_reg == ST_STANDBY));
	cov_wake_fail: cover property ((state_reg == ST_WAKE_WAIT) ##1 (state_reg == ST_SLEEP));
	cov_cfg_to_video: cover property ((state_reg == ST_CFG) ##1 (state_reg == ST_VIDEO));
endmodule

// ==== core/ssl_sync.sv ====
`timescale 1ns/100ps
module ssl_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// pins
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("ssl_sync: WIDTH must be at least 1");
		end
	endgenerate

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;
endmodule

// ==== core/ssl_timer.sv ====
`timescale 1ns/100ps
module ssl_timer #(
	parameter int unsigned CYCLES = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// control
	input wire logic start_in,
	input wire logic run_in,
	output logic expired_out
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
	logic [CW-1:0] count_reg;
	logic armed_reg;

	generate
		if (CYCLES < 2) begin : g_chk
			$error("ssl_timer: CYCLES must be at least 2");
		end
	endgenerate

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_reg <= '0;
			armed_reg <= 1'b0;
		end else if (start_in) begin
			count_reg <= LOAD;
			armed_reg <= 1'b1;
		end else if (run_in && armed_reg) begin
			if (count_reg == '0) begin
				armed_reg <= 1'b0;
			end else begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	assign expired_out = run_in && armed_reg && (count_reg == '0);
endmodule

// ==== shared/ssl_pkg.sv ====
package ssl_pkg;
	localparam int unsigned APB_AW = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam int unsigned CTRL_SLEEP_BIT = 0;
	localparam int unsigned CTRL_SLE_BIT = 1;
	localparam int unsigned CTRL_CLE_BIT = 2;
	localparam logic CTRL_SLEEP_RST = 1'b0;
	localparam logic CTRL_SLE_RST = 1'b0;
	localparam logic CTRL_CLE_RST = 1'b0;
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_LOCK_BIT = 8;
	localparam int unsigned STAT_CCRDY_BIT = 9;
	localparam int unsigned STAT_MCU_BIT = 10;
	localparam int unsigned STAT_STRAP_LSB = 11;
	localparam int unsigned CLK_FREQ_MHZ = 50;
	localparam int unsigned SLEEP_TIMEOUT_US = 8000;
	localparam int unsigned SLEEP_TIMEOUT_CYC = SLEEP_TIMEOUT_US * CLK_FREQ_MHZ;
	// synchronised pin vector positions
	localparam int unsigned IN_PD = 0;
	localparam int unsigned IN_SIDE_SEL = 1;
	localparam int unsigned IN_AUTOSTART = 2;
	localparam int unsigned IN_REMOTE_SLEEP = 3;
	localparam int unsigned IN_PCLK_OK = 4;
	localparam int unsigned IN_OSC_OK = 5;
	localparam int unsigned IN_ACT = 6;
	localparam int unsigned IN_VLOCK = 7;
	localparam int unsigned IN_CLOCK = 8;
	localparam int unsigned IN_WSIG = 9;
	localparam int unsigned IN_WFRAME = 10;
	localparam int unsigned SYNC_W = 11;
	typedef enum logic [6:0] {
		ST_OFF = 7'h01,
		ST_STANDBY = 7'h02,
		ST_SLEEP = 7'h04,
		ST_SLEEP_PEND = 7'h08,
		ST_WAKE_WAIT = 7'h10,
		ST_CFG = 7'h20,
		ST_VIDEO = 7'h40
	} ssl_state_e;
endpackage

// ==== tb/serial_link_startup_sleep_control_test.sv ====
`timescale 1ns/100ps
module serial_link_startup_sleep_control_test;
	import ssl_pkg::*;
	localparam int unsigned TMO = 20;
	logic clk_in, arst_n_in, psel, penable, pwrite, pready, pslverr;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pd_n, side_sel, autostart_n, remote_sleep, pclk_ok, osc_ok, send_wake;
	logic psel_d, pready_d, pslverr_d, tgt, d_pd_n, d_tx, d_act, d_vlock, d_clock, d_wsig;
	logic d_par_en, d_lock, d_ccrdy, d_lowp;
	logic [31:0] prdata_d;
	logic act, vlock, clock, wframe, tx_en, osc_sel, par_en, lock, wsig, ccrdy, lowp;
	int errors, tests_run, n;
	ssl_core #(.IS_DESER(1'b0), .SLEEP_TIMEOUT_CYCLES(TMO)) dut_u (
		.clk_in(clk_in), .arst_n_in(arst_n_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.powerdown_n_in(pd_n), .control_side_select_in(side_sel),
		.autostart_strap_n_in(autostart_n), .remote_sleep_start_strap_in(remote_sleep),
		.pixel_clock_locked_in(pclk_ok), .osc_locked_in(osc_ok), .link_activity_in(act),
		.video_lock_in(vlock), .config_lock_in(clock), .wake_signal_in(1'b0),
		.wake_frame_in(wframe), .tx_enable_out(tx_en), .osc_clock_select_out(osc_sel),
		.parallel_out_enable_out(par_en), .lock_out(lock), .wake_signal_out(wsig),
		.ctrl_channel_ready_out(ccrdy), .low_power_out(lowp)
	);
	ssl_far_model far_u (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .tx_enable_in(tx_en),
		.osc_clock_select_in(osc_sel), .send_wake_in(send_wake),
		.link_activity_out(act), .video_lock_out(vlock), .config_lock_out(clock),
		.wake_frame_out(wframe)
	);
	ssl_core #(.IS_DESER(1'b1), .SLEEP_TIMEOUT_CYCLES(TMO)) dut_deser_u (
		.clk_in(clk_in), .arst_n_in(arst_n_in),
		.psel_in(psel_d), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata_d), .pready_out(pready_d),
		.pslverr_out(pslverr_d), .powerdown_n_in(d_pd_n), .control_side_select_in(side_sel),
		.autostart_strap_n_in(1'b1), .remote_sleep_start_strap_in(remote_sleep),
		.pixel_clock_locked_in(1'b0), .osc_locked_in(1'b0), .link_activity_in(d_act),
		.video_lock_in(d_vlock), .config_lock_in(d_clock), .wake_signal_in(d_wsig),
		.wake_frame_in(1'b0), .tx_enable_out(), .osc_clock_select_out(),
		.parallel_out_enable_out(d_par_en), .lock_out(d_lock), .wake_signal_out(),
		.ctrl_channel_ready_out(d_ccrdy), .low_power_out(d_lowp)
	);
	ssl_far_model far_d_u (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .tx_enable_in(d_tx),
		.osc_clock_select_in(1'b0), .send_wake_in(send_wake),
		.link_activity_out(d_act), .video_lock_out(d_vlock), .config_lock_out(d_clock),
		.wake_frame_out(d_wsig)
	);
	always #10 clk_in = ~clk_in;
	task automatic end_of_test();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int k;
		@(posedge clk_in);
		psel <= !tgt;
		psel_d <= tgt;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while ((tgt ? pready_d : pready) !== 1'b1 && k < 50);
		rd = tgt ? prdata_d : prdata;
		err = tgt ? pslverr_d : pslverr;
		psel <= 1'b0;
		psel_d <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic apb_write(input logic [7:0] addr, input logic [31:0] wd);
		logic [31:0] rd;
		logic err;
		apb_xfer(1'b1, addr, wd, rd, err);
	endtask
	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic err;
		apb_xfer(1'b0, addr, 32'h0000_0000, rd, err);
		chk_word(rd, exp);
		chk_bit(err, exp_err);
	endtask
	// poll status until the masked field matches
	task automatic wait_status(input logic [31:0] mask, input logic [31:0] val, input int tries);
		logic [31:0] rd;
		logic err;
		int k;
		k = 0;
		do begin
			apb_xfer(1'b0, STATUS_OFS, 32'h0000_0000, rd, err);
			k++;
		end while ((rd & mask) !== val && k < tries);
		chk_word(rd & mask, val);
		if ((rd & mask) !== val) begin
			end_of_test();
		end
	endtask
	task automatic wake_pulse();
		@(posedge clk_in);
		send_wake <= 1'b1;
		@(posedge clk_in);
		send_wake <= 1'b0;
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		errors++;
		$display("Error at %0t: run did not finish", $time);
		end_of_test();
	end
	initial begin
		clk_in = 1'b0;
		arst_n_in = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{pd_n, side_sel, autostart_n, remote_sleep, pclk_ok, osc_ok, send_wake} = 7'b0010000;
		{psel_d, tgt, d_pd_n, d_tx} = '0;
		errors = 0;
		tests_run = 0;
		repeat (16) @(posedge clk_in);
		arst_n_in <= 1'b1;
		wait_status(32'h0000_007F, 32'h0000_0001, 5);
		chk_bit(lowp, 1'b1);
		rd_chk(8'h08, 32'h0000_0000, 1'b1);
		// display setup, standby start
		pd_n <= 1'b1;
		wait_status(32'h0000_007F, 32'h0000_0002, 10);
		chk_bit(tx_en, 1'b0);
		wait_status(32'h0000_3C00, 32'h0000_1400, 1);
		apb_write(CTRL_OFS, 32'h0000_0001);
		rd_chk(CTRL_OFS, 32'h0000_0000, 1'b0);
		chk_bit(lowp, 1'b0);
		apb_write(CTRL_OFS, 32'h0000_0004);
		osc_ok <= 1'b1;
		wait_status(32'h0000_007F, 32'h0000_0020, 10);
		wait_status(32'h0000_0200, 32'h0000_0200, 20);
		chk_bit(osc_sel, 1'b1);
		chk_bit(par_en, 1'b0);
		chk_bit(lock, 1'b0);
		apb_write(CTRL_OFS, 32'h0000_0006);
		wait_status(32'h0000_007F, 32'h0000_0040, 5);
		chk_bit(osc_sel, 1'b0);
		chk_bit(tx_en, 1'b0);
		pclk_ok <= 1'b1;
		n = 0;
		while (tx_en !== 1'b1 && n < 20) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk_bit(tx_en, 1'b1);
		@(posedge clk_in);
		#1;
		chk_bit(wsig, 1'b1);
		@(posedge clk_in);
		#1;
		chk_bit(wsig, 1'b0);
		wait_status(32'h0000_0100, 32'h0000_0100, 20);
		chk_bit(lock, 1'b1);
		chk_bit(ccrdy, 1'b1);
		// camera setup, serializer starts asleep
		pd_n <= 1'b0;
		pclk_ok <= 1'b0;
		osc_ok <= 1'b0;
		wait_status(32'h0000_007F, 32'h0000_0001, 10);
		side_sel <= 1'b1;
		pd_n <= 1'b1;
		wait_status(32'h0000_007F, 32'h0000_0004, 10);
		side_sel <= 1'b0;
		rd_chk(CTRL_OFS, 32'h0000_0001, 1'b0);
		chk_bit(lowp, 1'b1);
		wait_status(32'h0000_3C00, 32'h0000_1800, 1);
		wake_pulse();
		wait_status(32'h0000_007F, 32'h0000_0010, 10);
		wait_status(32'h0000_007F, 32'h0000_0004, 40);
		wake_pulse();
		wait_status(32'h0000_007F, 32'h0000_0010, 10);
		apb_write(CTRL_OFS, 32'h0000_0000);
		wait_status(32'h0000_007F, 32'h0000_0002, 5);
		chk_bit(lowp, 1'b0);
		apb_write(CTRL_OFS, 32'h0000_0001);
		wait_status(32'h0000_007F, 32'h0000_0004, 2);
		// camera setup, autostart
		pd_n <= 1'b0;
		wait_status(32'h0000_007F, 32'h0000_0001, 10);
		side_sel <= 1'b1;
		autostart_n <= 1'b0;
		pd_n <= 1'b1;
		pclk_ok <= 1'b1;
		wait_status(32'h0000_007F, 32'h0000_0040, 10);
		rd_chk(CTRL_OFS, 32'h0000_0002, 1'b0);
		wait_status(32'h0000_0100, 32'h0000_0100, 20);
		// deserializer, display sleep start, woken by the serializer
		tgt = 1'b1;
		side_sel <= 1'b0;
		remote_sleep <= 1'b1;
		d_pd_n <= 1'b1;
		wait_status(32'h0000_007F, 32'h0000_0004, 10);
		rd_chk(CTRL_OFS, 32'h0000_0001, 1'b0);
		chk_bit(d_lowp, 1'b1);
		chk_bit(d_par_en, 1'b0);
		wake_pulse();
		wait_status(32'h0000_007F, 32'h0000_0010, 10);
		wait_status(32'h0000_007F, 32'h0000_0004, 40);
		rd_chk(CTRL_OFS, 32'h0000_0001, 1'b0);
		wake_pulse();
		d_tx <= 1'b1;
		wait_status(32'h0000_017F, 32'h0000_0102, 20);
		rd_chk(CTRL_OFS, 32'h0000_0000, 1'b0);
		chk_bit(d_lock, 1'b1);
		chk_bit(d_par_en, 1'b1);
		chk_bit(d_ccrdy, 1'b1);
		// sleep on inactivity, then on timeout with traffic
		apb_write(CTRL_OFS, 32'h0000_0001);
		wait_status(32'h0000_007F, 32'h0000_0008, 3);
		d_tx <= 1'b0;
		wait_status(32'h0000_007F, 32'h0000_0004, 3);
		chk_bit(d_lowp, 1'b1);
		apb_write(CTRL_OFS, 32'h0000_0000);
		d_tx <= 1'b1;
		wait_status(32'h0000_007F, 32'h0000_0002, 5);
		apb_write(CTRL_OFS, 32'h0000_0001);
		wait_status(32'h0000_007F, 32'h0000_0008, 3);
		wait_status(32'h0000_007F, 32'h0000_0004, 20);
		// deserializer, camera setup, controller side
		d_pd_n <= 1'b0;
		wait_status(32'h0000_007F, 32'h0000_0001, 10);
		side_sel <= 1'b1;
		d_pd_n <= 1'b1;
		wait_status(32'h0000_007F, 32'h0000_0002, 10);
		rd_chk(CTRL_OFS, 32'h0000_0000, 1'b0);
		wait_status(32'h0000_0100, 32'h0000_0100, 10);
		wait_status(32'h0000_0400, 32'h0000_0400, 1);
		apb_write(CTRL_OFS, 32'h0000_0001);
		rd_chk(CTRL_OFS, 32'h0000_0000, 1'b0);
		wake_pulse();
		repeat (4) @(posedge clk_in);
		wait_status(32'h0000_007F, 32'h0000_0002, 1);
		end_of_test();
	end
endmodule

// ==== tb/ssl_far_model.sv ====
`timescale 1ns/100ps
module ssl_far_model #(
	parameter int unsigned LOCK_DLY = 6
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// near-end link control
	input wire logic tx_enable_in,
	input wire logic osc_clock_select_in,
	input wire logic send_wake_in,
	// far-end status
	output logic link_activity_out,
	output logic video_lock_out,
	output logic config_lock_out,
	output logic wake_frame_out
);
	logic [7:0] lock_cnt_reg;
	logic [2:0] wake_cnt_reg;
	logic locked;
	// host clamps the spread divider it computes to the table limit
	localparam int unsigned DIV_LIMIT = 63;
	localparam int unsigned DIV_WANT = 70;
	localparam int unsigned DIV_SET = (DIV_WANT > DIV_LIMIT) ? DIV_LIMIT : DIV_WANT;
	// receiver needs some traffic before it locks
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lock_cnt_reg <= 8'h00;
			wake_cnt_reg <= 3'h0;
		end else begin
			if (!(tx_enable_in || osc_clock_select_in)) begin
				lock_cnt_reg <= 8'h00;
			end else if (!locked) begin
				lock_cnt_reg <= lock_cnt_reg + 8'h01;
			end
			// wake receiver flags a frame with enough edges
			if (send_wake_in) begin
				wake_cnt_reg <= 3'h4;
			end else if (wake_cnt_reg != 3'h0) begin
				wake_cnt_reg <= wake_cnt_reg - 3'h1;
			end
		end
	end
	assign locked = (lock_cnt_reg == 8'(LOCK_DLY));
	assign link_activity_out = tx_enable_in || osc_clock_select_in;
	assign video_lock_out = locked && tx_enable_in && !osc_clock_select_in;
	assign config_lock_out = locked && osc_clock_select_in;
	assign wake_frame_out = (wake_cnt_reg != 3'h0);
endmodule
